// ---- verilog/cursor_screen_defines.svh ----
// register map, field positions and reset values of the cursor and screen block
`ifndef CURSOR_SCREEN_DEFINES_SVH
`define CURSOR_SCREEN_DEFINES_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_CURSOR_TRANSPARENCY 10'h0A0
`define IDX_CURSOR_PRIORITY     10'h0A2
`define IDX_CURSOR_A_BASE       10'h0A4
`define IDX_CURSOR_A_X          10'h0A8
`define IDX_CURSOR_A_Y          10'h0AA
`define IDX_CURSOR_B_BASE       10'h0AC
`define IDX_CURSOR_B_X          10'h0B0
`define IDX_CURSOR_B_Y          10'h0B2
`define IDX_DUAL_SCREEN         10'h170

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TRC_CODE_MSB     7
`define TRC_ZERO_BIT     8
`define PRI_A_OVER_BIT   0
`define PRI_B_OVER_BIT   1
`define PRI_A_SHOW_BIT   4
`define PRI_B_SHOW_BIT   5
`define BASE_MSB         25
`define BASE_LSB         4
`define POS_MSB          11
`define DSC_S0_LSB       0
`define DSC_S1_LSB       8
`define DSC_A_OFS        6
`define DSC_B_OFS        7
`define DSC_DUAL_BIT     31

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_TRC_CODE     8'h00
`define RST_BASE         22'h000000
`define RST_POS          12'h000
`define RST_SOURCES      8'h00

`endif

// ---- verilog/cursor_screen_pkg.sv ----
// types shared by the cursor and screen block
package cursor_screen_pkg;

   typedef enum logic [0:0] {
      BUS_IDLE    = 1'b0,
      BUS_RD_WAIT = 1'b1
   } bus_state_t;

endpackage : cursor_screen_pkg

// ---- verilog/cursor_pixel_gate.sv ----
// decides whether one cursor puts a visible pixel at the current position
`timescale 1ns/1ps
module cursor_pixel_gate #(
   parameter int SIZE = 64
) (
   input  wire logic        show,
   input  wire logic [11:0] pix_x,
   input  wire logic [11:0] pix_y,
   input  wire logic [11:0] pos_x,
   input  wire logic [11:0] pos_y,
   input  wire logic [7:0]  code,
   input  wire logic [7:0]  trans_code,
   input  wire logic        zero_transparent,
   output logic             visible
);
   logic [12:0] dx;
   logic [12:0] dy;
   logic        hit;
   logic        clear_px;

   // position marks the top-left pixel of the pattern
   assign dx  = {1'b0, pix_x} - {1'b0, pos_x};
   assign dy  = {1'b0, pix_y} - {1'b0, pos_y};
   assign hit = !dx[12] && !dy[12] && (dx < 13'(SIZE)) && (dy < 13'(SIZE));

   assign clear_px = (code == trans_code) ||
                     (zero_transparent && (code == 8'h00));

   assign visible = show && hit && !clear_px;

endmodule : cursor_pixel_gate

// ---- verilog/cursor_screen_ctrl.sv ----
// cursor overlay registers, per-screen cursor selection and AHB-Lite slave
// Contract
// - cursor 0 always in front of cursor 1
// - priority bit 0: cursor 0 over base
// - priority bit 1: cursor 1 over base
// - bits 4/5 enable cursors, reset off
// - cursor 0 base 16-byte aligned
// - cursor 1 base 16-byte aligned
// - cursor 0 placed by 12-bit x/y
// - cursor 1 placed by 12-bit x/y
// - dual select bit 31, 30:16 zero
// - bits 0..7 pick screen 0 sources
// - bits 8..13 pick screen 1 layers
// - zero-transparency makes code 0 clear
// - matching transparency code is clear
// - zero-transparency off: code 0 opaque (code keeps it clear while the transparency code is 0)
// - dual select 0 single, 1 dual
// - bits 14/15 put cursors on screen 1
`timescale 1ns/1ps
`include "cursor_screen_defines.svh"
module cursor_screen_ctrl
   import cursor_screen_pkg::*;
#(
   parameter int CURSOR_SIZE = 64
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [11:0] pix_x,
   input  wire logic [11:0] pix_y,
   input  wire logic [7:0]  cursor_a_code,
   input  wire logic [7:0]  cursor_b_code,
   output logic [31:0]      cursor_a_pattern_base,
   output logic [31:0]      cursor_b_pattern_base,
   output logic             dual_mode,
   output logic [5:0]       screen0_layers,
   output logic [5:0]       screen1_layers,
   output logic [1:0]       scr_cursor_valid,
   output logic [1:0]       scr_cursor_id,
   output logic [1:0]       scr_cursor_over_base,
   output logic [15:0]      scr_cursor_code
);

   initial begin
      if (CURSOR_SIZE < 1 || CURSOR_SIZE > 4096) begin
         $error("CURSOR_SIZE out of range");
      end
   end

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic [7:0]  cursor_transparent_code;
   logic        zero_code_transparent;
   logic        cursor_a_over_base;
   logic        cursor_b_over_base;
   logic        cursor_a_show;
   logic        cursor_b_show;
   logic [21:0] base_a;
   logic [21:0] base_b;
   logic [11:0] cursor_a_x;
   logic [11:0] cursor_a_y;
   logic [11:0] cursor_b_x;
   logic [11:0] cursor_b_y;
   logic        dual_screen_select;
   logic [7:0]  first_screen_sources;
   logic [7:0]  second_screen_sources;

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   bus_state_t  state;
   logic        accept;
   logic        wr_pend;
   logic [9:0]  wr_idx;
   logic [9:0]  rd_idx;
   logic        wr_en;
   logic [31:0] rd_word;

   assign accept    = hsel && hready && htrans[1];
   assign hreadyout = (state == BUS_IDLE);
   assign hresp     = 1'b0;
   assign wr_en     = wr_pend;

   // reads take one wait state so that hrdata comes from a flop and
   // already sees a write that was in its data phase just before
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= BUS_IDLE;
      end else begin
         unique case (state)
            BUS_IDLE: begin
               if (accept && !hwrite) begin
                  state <= BUS_RD_WAIT;
               end
            end
            BUS_RD_WAIT: begin
               state <= BUS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_idx  <= 10'h000;
         rd_idx  <= 10'h000;
      end else begin
         wr_pend <= accept && hwrite;
         if (accept) begin
            wr_idx <= haddr[11:2];
            rd_idx <= haddr[11:2];
         end
      end
   end

   // hsize is not checked: only whole-word transfers are supported
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (rd_idx)
         `IDX_CURSOR_TRANSPARENCY: begin
            rd_word[`TRC_CODE_MSB:0] = cursor_transparent_code;
            rd_word[`TRC_ZERO_BIT]   = zero_code_transparent;
         end
         `IDX_CURSOR_PRIORITY: begin
            rd_word[`PRI_A_OVER_BIT] = cursor_a_over_base;
            rd_word[`PRI_B_OVER_BIT] = cursor_b_over_base;
            rd_word[`PRI_A_SHOW_BIT] = cursor_a_show;
            rd_word[`PRI_B_SHOW_BIT] = cursor_b_show;
         end
         `IDX_CURSOR_A_BASE: rd_word = cursor_a_pattern_base;
         `IDX_CURSOR_B_BASE: rd_word = cursor_b_pattern_base;
         `IDX_CURSOR_A_X:    rd_word[`POS_MSB:0] = cursor_a_x;
         `IDX_CURSOR_A_Y:    rd_word[`POS_MSB:0] = cursor_a_y;
         `IDX_CURSOR_B_X:    rd_word[`POS_MSB:0] = cursor_b_x;
         `IDX_CURSOR_B_Y:    rd_word[`POS_MSB:0] = cursor_b_y;
         `IDX_DUAL_SCREEN: begin
            rd_word[`DSC_DUAL_BIT]         = dual_screen_select;
            rd_word[`DSC_S1_LSB +: 8]      = second_screen_sources;
            rd_word[`DSC_S0_LSB +: 8]      = first_screen_sources;
         end
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (state == BUS_RD_WAIT) begin
         hrdata <= rd_word;
      end
   end

   // ----------------------------------------------------------------
   // registers written by software
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cursor_transparent_code <= `RST_TRC_CODE;
         zero_code_transparent   <= 1'b0;
      end else if (wr_en && wr_idx == `IDX_CURSOR_TRANSPARENCY) begin
         cursor_transparent_code <= hwdata[`TRC_CODE_MSB:0];
         zero_code_transparent   <= hwdata[`TRC_ZERO_BIT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cursor_a_over_base <= 1'b0;
         cursor_b_over_base <= 1'b0;
         cursor_a_show      <= 1'b0;
         cursor_b_show      <= 1'b0;
      end else if (wr_en && wr_idx == `IDX_CURSOR_PRIORITY) begin
         cursor_a_over_base <= hwdata[`PRI_A_OVER_BIT];
         cursor_b_over_base <= hwdata[`PRI_B_OVER_BIT];
         cursor_a_show      <= hwdata[`PRI_A_SHOW_BIT];
         cursor_b_show      <= hwdata[`PRI_B_SHOW_BIT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         base_a <= `RST_BASE;
         base_b <= `RST_BASE;
      end else if (wr_en) begin
         if (wr_idx == `IDX_CURSOR_A_BASE) begin
            base_a <= hwdata[`BASE_MSB:`BASE_LSB];
         end
         if (wr_idx == `IDX_CURSOR_B_BASE) begin
            base_b <= hwdata[`BASE_MSB:`BASE_LSB];
         end
      end
   end

   assign cursor_a_pattern_base = {6'h00, base_a, 4'h0};
   assign cursor_b_pattern_base = {6'h00, base_b, 4'h0};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cursor_a_x <= `RST_POS;
         cursor_a_y <= `RST_POS;
         cursor_b_x <= `RST_POS;
         cursor_b_y <= `RST_POS;
      end else if (wr_en) begin
         if (wr_idx == `IDX_CURSOR_A_X) begin
            cursor_a_x <= hwdata[`POS_MSB:0];
         end
         if (wr_idx == `IDX_CURSOR_A_Y) begin
            cursor_a_y <= hwdata[`POS_MSB:0];
         end
         if (wr_idx == `IDX_CURSOR_B_X) begin
            cursor_b_x <= hwdata[`POS_MSB:0];
         end
         if (wr_idx == `IDX_CURSOR_B_Y) begin
            cursor_b_y <= hwdata[`POS_MSB:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dual_screen_select    <= 1'b0;
         first_screen_sources  <= `RST_SOURCES;
         second_screen_sources <= `RST_SOURCES;
      end else if (wr_en && wr_idx == `IDX_DUAL_SCREEN) begin
         dual_screen_select    <= hwdata[`DSC_DUAL_BIT];
         first_screen_sources  <= hwdata[`DSC_S0_LSB +: 8];
         second_screen_sources <= hwdata[`DSC_S1_LSB +: 8];
      end
   end

   // ----------------------------------------------------------------
   // cursor visibility and per-screen selection
   // ----------------------------------------------------------------
   logic [1:0]  vis;
   logic [1:0]  show;
   logic [23:0] pos_x;
   logic [23:0] pos_y;
   logic [15:0] codes;
   logic [1:0]  over;
   logic [3:0]  incl;
   wire logic [1:0]  next_valid;
   wire logic [1:0]  next_id;
   wire logic [1:0]  next_over;
   wire logic [15:0] next_code;

   assign show  = {cursor_b_show, cursor_a_show};
   assign pos_x = {cursor_b_x, cursor_a_x};
   assign pos_y = {cursor_b_y, cursor_a_y};
   assign codes = {cursor_b_code, cursor_a_code};
   assign over  = {cursor_b_over_base, cursor_a_over_base};

   // incl[2*s+c]: cursor c is a source of screen s; screen 1 only in dual mode
   assign incl[0] = first_screen_sources[`DSC_A_OFS];
   assign incl[1] = first_screen_sources[`DSC_B_OFS];
   assign incl[2] = dual_screen_select && second_screen_sources[`DSC_A_OFS];
   assign incl[3] = dual_screen_select && second_screen_sources[`DSC_B_OFS];

   assign dual_mode      = dual_screen_select;
   assign screen0_layers = first_screen_sources[5:0];
   assign screen1_layers = dual_screen_select ? second_screen_sources[5:0] : 6'h00;

   generate
      for (genvar c = 0; c < 2; c++) begin : g_cursor
         cursor_pixel_gate #(
            .SIZE (CURSOR_SIZE)
         ) u_gate (
            .show             (show[c]),
            .pix_x            (pix_x),
            .pix_y            (pix_y),
            .pos_x            (pos_x[12*c +: 12]),
            .pos_y            (pos_y[12*c +: 12]),
            .code             (codes[8*c +: 8]),
            .trans_code       (cursor_transparent_code),
            .zero_transparent (zero_code_transparent),
            .visible          (vis[c])
         );
      end

      // cursor 0 is tested first so it always sits in front of cursor 1
      for (genvar s = 0; s < 2; s++) begin : g_screen
         logic       pick_valid;
         logic       pick_id;
         logic       pick_over;
         logic [7:0] pick_code;

         always_comb begin
            pick_valid = 1'b0;
            pick_id    = 1'b0;
            pick_over  = 1'b0;
            pick_code  = 8'h00;
            if (vis[0] && incl[2*s]) begin
               pick_valid = 1'b1;
               pick_over  = over[0];
               pick_code  = codes[7:0];
            end else if (vis[1] && incl[2*s+1]) begin
               pick_valid = 1'b1;
               pick_id    = 1'b1;
               pick_over  = over[1];
               pick_code  = codes[15:8];
            end
         end

         // one driver per bit: each screen owns its own slice
         assign next_valid[s]       = pick_valid;
         assign next_id[s]          = pick_id;
         assign next_over[s]        = pick_over;
         assign next_code[8*s +: 8] = pick_code;
      end
   endgenerate

   // one pipeline stage; the compositor lines its base layer up to match
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scr_cursor_valid     <= 2'h0;
         scr_cursor_id        <= 2'h0;
         scr_cursor_over_base <= 2'h0;
         scr_cursor_code      <= 16'h0000;
      end else begin
         scr_cursor_valid     <= next_valid;
         scr_cursor_id        <= next_id;
         scr_cursor_over_base <= next_over;
         scr_cursor_code      <= next_code;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_a_front;
      (vis[0] && vis[1] && incl[0] && incl[1]) |=>
         (scr_cursor_valid[0] && !scr_cursor_id[0]);
   endproperty
   a_a_front: assert property (p_a_front) else $error("cursor 1 in front");

   property p_a_over;
      (vis[0] && incl[0]) |=> (scr_cursor_over_base[0] == $past(cursor_a_over_base));
   endproperty
   a_a_over: assert property (p_a_over) else $error("cursor 0 priority wrong");

   property p_b_over;
      (!(vis[0] && incl[0]) && vis[1] && incl[1]) |=>
         (scr_cursor_id[0] && scr_cursor_over_base[0] == $past(cursor_b_over_base));
   endproperty
   a_b_over: assert property (p_b_over) else $error("cursor 1 priority wrong");

   property p_hidden;
      (!cursor_a_show && !cursor_b_show) |=> (scr_cursor_valid == 2'h0);
   endproperty
   a_hidden: assert property (p_hidden) else $error("disabled cursor shown");

   property p_base_write;
      (wr_en && wr_idx == `IDX_CURSOR_A_BASE) |=>
         (cursor_a_pattern_base == {6'h00, $past(hwdata[25:4]), 4'h0});
   endproperty
   a_base_write: assert property (p_base_write) else $error("base write wrong");

   property p_pos_write;
      (wr_en && wr_idx == `IDX_CURSOR_B_X) |=> (cursor_b_x == $past(hwdata[11:0]));
   endproperty
   a_pos_write: assert property (p_pos_write) else $error("position write wrong");

   property p_dsc_read;
      (state == BUS_RD_WAIT && rd_idx == `IDX_DUAL_SCREEN) |=>
         (hreadyout && hrdata[30:16] == 15'h0000 && hrdata[31] == dual_screen_select);
   endproperty
   a_dsc_read: assert property (p_dsc_read) else $error("dual control read wrong");

   property p_zero_clear;
      (zero_code_transparent && cursor_a_code == 8'h00) |-> !vis[0];
   endproperty
   a_zero_clear: assert property (p_zero_clear) else $error("code 0 not clear");

   property p_single;
      !dual_screen_select |-> (screen1_layers == 6'h00) ##1 !scr_cursor_valid[1];
   endproperty
   a_single: assert property (p_single) else $error("screen 1 active single");

   property p_read_wait;
      (accept && !hwrite) |=> !hreadyout ##1 hreadyout;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("read timing wrong");

endmodule : cursor_screen_ctrl

// ---- dv/pixel_source.sv ----
// pixel stream model standing in for the compositing pipeline
`timescale 1ns/1ps
module pixel_source (
   input  wire logic        hclk,
   output logic [11:0]      pix_x,
   output logic [11:0]      pix_y,
   output logic [7:0]       code_a,
   output logic [7:0]       code_b
);
   // ----------------------------------------
   // scan position and pattern codes
   // ----------------------------------------
   initial begin
      pix_x  = 12'h000;
      pix_y  = 12'h000;
      code_a = 8'h00;
      code_b = 8'h00;
   end

   // changed just after an edge, held until the next put
   task automatic put(input logic [11:0] x, input logic [11:0] y,
                      input logic [7:0] a, input logic [7:0] b);
      @(posedge hclk);
      pix_x  <= x;
      pix_y  <= y;
      code_a <= a;
      code_b <= b;
   endtask : put
endmodule : pixel_source

// ---- dv/hw_cursor_and_screen_select_test.sv ----
// register and cursor selection tests for the cursor and screen block
`timescale 1ns/1ps
`include "cursor_screen_defines.svh"
module hw_cursor_and_screen_select_test;
   import cursor_screen_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [11:0] pix_x;
   logic [11:0] pix_y;
   logic [7:0]  code_a;
   logic [7:0]  code_b;
   logic [31:0] base_a;
   logic [31:0] base_b;
   logic        dual_mode;
   logic [5:0]  layers0;
   logic [5:0]  layers1;
   logic [1:0]  sv;
   logic [1:0]  sid;
   logic [1:0]  sover;
   logic [15:0] scode;
   logic [31:0] rd;
   int          err_count;
   int          num_checks;

   cursor_screen_ctrl #(.CURSOR_SIZE(64)) cursor_screen_ctrl_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pix_x(pix_x),
      .pix_y(pix_y), .cursor_a_code(code_a), .cursor_b_code(code_b),
      .cursor_a_pattern_base(base_a), .cursor_b_pattern_base(base_b),
      .dual_mode(dual_mode), .screen0_layers(layers0), .screen1_layers(layers1),
      .scr_cursor_valid(sv), .scr_cursor_id(sid), .scr_cursor_over_base(sover),
      .scr_cursor_code(scode));

   pixel_source pixel_source_inst (
      .hclk(hclk), .pix_x(pix_x), .pix_y(pix_y), .code_a(code_a), .code_b(code_b));

   // ----------------------------------------
   // clock, reset, watchdog
   // ----------------------------------------
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   initial begin
      #(25 * 4000);
      err_count++;
      results();
   end

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : chk

   // waits for hready at an edge; a lost answer is left to the watchdog
   task automatic wait_ready();
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask : wait_ready

   task automatic bus(input logic [9:0] idx, input logic wr, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr  <= {idx, 2'b00};
      wait_ready();
      htrans <= 2'b00;
      hwdata <= wr ? d : 32'h00000000;
      wait_ready();
      rd = hrdata;
      hsel <= 1'b0;
   endtask : bus

   task automatic rchk(input logic [9:0] idx, input logic [31:0] exp);
      bus(idx, 1'b0, 32'h00000000);
      chk(rd, exp);
   endtask : rchk

   // result shows one edge after the pixel is presented
   task automatic pchk(input logic [11:0] x, input logic [11:0] y, input logic [7:0] a,
                       input logic [7:0] b, input logic [1:0] v, input logic [1:0] i,
                       input logic [1:0] o, input logic [15:0] c);
      pixel_source_inst.put(x, y, a, b);
      @(posedge hclk);
      @(posedge hclk);
      #1;
      chk({10'h000, sv, sid, sover, scode}, {10'h000, v, i, o, c});
   endtask : pchk

   task automatic results();
      $display("checks=%0d errors=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      err_count  = 0;
      num_checks = 0;
      hresetn = 1'b0;
      hsel    = 1'b0;
      haddr   = 12'h000;
      htrans  = 2'b00;
      hwrite  = 1'b0;
      hsize   = 3'h2;
      hwdata  = 32'h00000000;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      rchk(`IDX_CURSOR_PRIORITY, 32'h00000000);
      chk({31'h0, dual_mode}, 32'h00000000);
      bus(`IDX_CURSOR_PRIORITY, 1'b1, 32'hFFFFFFFF);
      rchk(`IDX_CURSOR_PRIORITY, 32'h00000033);
      bus(`IDX_CURSOR_PRIORITY, 1'b1, 32'h00000000);
      bus(`IDX_CURSOR_A_BASE, 1'b1, 32'hFFFFFFFF);
      rchk(`IDX_CURSOR_A_BASE, 32'h03FFFFF0);
      chk(base_a, 32'h03FFFFF0);
      bus(`IDX_CURSOR_B_BASE, 1'b1, 32'hFFFFFFFF);
      rchk(`IDX_CURSOR_B_BASE, 32'h03FFFFF0);
      chk(base_b, 32'h03FFFFF0);
      bus(`IDX_CURSOR_A_X, 1'b1, 32'hFFFFFFFF);
      rchk(`IDX_CURSOR_A_X, 32'h00000FFF);
      bus(`IDX_CURSOR_B_Y, 1'b1, 32'hFFFFFFFF);
      rchk(`IDX_CURSOR_B_Y, 32'h00000FFF);
      rchk(10'h0A1, 32'h00000000);
      chk({31'h0, hresp}, 32'h00000000);
      bus(`IDX_DUAL_SCREEN, 1'b1, 32'hFFFFFFFF);
      rchk(`IDX_DUAL_SCREEN, 32'h8000FFFF);
      chk({26'h0, layers1}, 32'h0000003F);
      chk({31'h0, dual_mode}, 32'h00000001);
      bus(`IDX_DUAL_SCREEN, 1'b1, 32'h00000115);
      #1;
      chk({26'h0, layers0}, 32'h00000015);
      chk({25'h0, dual_mode, layers1}, 32'h00000000);
      // cursors fully set up before either is shown
      bus(`IDX_CURSOR_TRANSPARENCY, 1'b1, 32'h00000155);
      bus(`IDX_CURSOR_A_X, 1'b1, 32'h00000064);
      bus(`IDX_CURSOR_A_Y, 1'b1, 32'h00000064);
      bus(`IDX_CURSOR_B_X, 1'b1, 32'h0000006E);
      bus(`IDX_CURSOR_B_Y, 1'b1, 32'h0000006E);
      bus(`IDX_DUAL_SCREEN, 1'b1, 32'h8000C0C0);
      bus(`IDX_CURSOR_PRIORITY, 1'b1, 32'h00000031);
      pchk(12'd120, 12'd120, 8'h12, 8'h34, 2'b11, 2'b00, 2'b11, 16'h1212);
      pchk(12'd170, 12'd170, 8'h12, 8'h34, 2'b11, 2'b11, 2'b00, 16'h3434);
      pchk(12'd120, 12'd120, 8'h55, 8'h34, 2'b11, 2'b11, 2'b00, 16'h3434);
      pchk(12'd120, 12'd120, 8'h00, 8'h34, 2'b11, 2'b11, 2'b00, 16'h3434);
      bus(`IDX_CURSOR_TRANSPARENCY, 1'b1, 32'h00000055);
      pchk(12'd120, 12'd120, 8'h00, 8'h34, 2'b11, 2'b00, 2'b11, 16'h0000);
      bus(`IDX_CURSOR_PRIORITY, 1'b1, 32'h00000023);
      pchk(12'd120, 12'd120, 8'h12, 8'h34, 2'b11, 2'b11, 2'b11, 16'h3434);
      bus(`IDX_CURSOR_PRIORITY, 1'b1, 32'h00000012);
      pchk(12'd120, 12'd120, 8'h12, 8'h34, 2'b11, 2'b00, 2'b00, 16'h1212);
      bus(`IDX_CURSOR_PRIORITY, 1'b1, 32'h00000033);
      bus(`IDX_DUAL_SCREEN, 1'b1, 32'h80008040);
      pchk(12'd120, 12'd120, 8'h12, 8'h34, 2'b11, 2'b10, 2'b11, 16'h3412);
      pchk(12'd163, 12'd163, 8'h12, 8'h34, 2'b11, 2'b10, 2'b11, 16'h3412);
      results();
   end
endmodule : hw_cursor_and_screen_select_test
